// file: core/phase_adjust_pkg.sv
// constants, register map and field layouts of the output phase adjuster
package phase_adjust_pkg;

	localparam int unsigned NUM_ADJ_CHANNELS = 7;
	localparam int unsigned NUM_CHANNELS     = 12;
	localparam int unsigned RATIO1_WIDTH     = 8;
	localparam int unsigned RATIO2_WIDTH     = 16;
	localparam int unsigned FINE_WIDTH       = 4;

	// -----------------------------------------------------------
	// register map (byte addresses)
	// -----------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] STATUS_OFFSET   = 8'h04;
	localparam logic [7:0] STEP_OFFSET     = 8'h08;
	localparam logic [7:0] CHAN_BASE       = 8'h10;
	localparam logic [7:0] CHAN_STRIDE     = 8'h08;
	localparam logic [7:0] DIV_SUB_OFFSET  = 8'h00;
	localparam logic [7:0] PH_SUB_OFFSET   = 8'h04;

	// ctrl fields
	localparam int unsigned CTRL_ALIGN_BIT = 0;
	localparam int unsigned CTRL_VCO_LSB   = 4;

	// -----------------------------------------------------------
	// reset values
	// -----------------------------------------------------------
	localparam logic [7:0]  RATIO1_RESET = 8'h01;
	localparam logic [15:0] RATIO2_RESET = 16'h0002;

	// -----------------------------------------------------------
	// oscillator plans and step sizes
	// -----------------------------------------------------------
	typedef enum logic [1:0]
	{
		VCO_ETHERNET = 2'b00,
		VCO_LAN_PHY  = 2'b01,
		VCO_SONET    = 2'b10
	} vco_plan_type;

	localparam int unsigned VCO_ETHERNET_KHZ = 2500000;
	localparam int unsigned VCO_LAN_PHY_KHZ  = 2578125;
	localparam int unsigned VCO_SONET_KHZ    = 2488320;
	// half an oscillator period in femtoseconds
	localparam longint unsigned FS_PER_KHZ_HALF = 64'd500000000000;
	localparam int unsigned COARSE_MIN_STEP_PS = 1600;
	localparam int unsigned FINE_MIN_STEP_FS   = 187270;

	typedef struct packed
	{
		logic [RATIO2_WIDTH-1:0] ratio2;
		logic [RATIO1_WIDTH-1:0] ratio1;
	} divider_ratio_type;

	typedef struct packed
	{
		logic                    analog_src;
		logic [2:0]              spare;
		logic [FINE_WIDTH-1:0]   fine;
		logic [RATIO2_WIDTH-1:0] phase2;
		logic [RATIO1_WIDTH-1:0] phase1;
	} phase_setting_type;

endpackage

// file: core/phase_divider.sv
// one output channel: two cascaded dividers with start offsets and fine tap
module phase_divider
	import phase_adjust_pkg::*;
#(
	parameter int unsigned R1W = 8,
	parameter int unsigned R2W = 16,
	parameter int unsigned FW  = 4
)
(
	input  wire logic           sys_clk,
	input  wire logic           resetn,
	input  wire logic           div_tick,
	input  wire logic           fine_tick,
	input  wire logic           load,
	input  wire logic [R1W-1:0] ratio1,
	input  wire logic [R2W-1:0] ratio2,
	input  wire logic [R1W-1:0] phase1,
	input  wire logic [R2W-1:0] phase2,
	input  wire logic [FW-1:0]  fine,
	input  wire logic           analog_src,
	output logic                clk_out
);

	// -----------------------------------------------------------
	// start count: edge lands phase stage counts later; stage two counts stage-one wraps
	// -----------------------------------------------------------
	// the stage starts behind its wrap by the phase, one further when
	// the stage below borrows; a phase past the ratio counts as zero
	function automatic logic [15:0] start_count(input logic [15:0] ratio,
		input logic [15:0] phase, input logic borrow);
		logic [16:0] t;
		t = 17'(ratio) - 17'(borrow);
		if (phase <= ratio)
			t = t - 17'(phase);
		if (t[16])
			t = t + 17'(ratio);
		if (t[15:0] >= ratio)
			t = '0;
		return t[15:0];
	endfunction

	function automatic logic [15:0] last_count(input logic [15:0] ratio);
		return (ratio == 16'h0000) ? 16'h0000 : 16'(ratio - 16'h0001);
	endfunction

	logic [R1W-1:0]  c1_q;
	logic [R2W-1:0]  c2_q;
	logic            level_q;
	logic [2**FW-2:0] dl_q;
	logic            wrap1;
	logic            wrap2;
	logic            borrow1;
	logic [2**FW-1:0] taps;

	assign wrap1 = div_tick && (16'(c1_q) >= last_count(16'(ratio1)));
	assign wrap2 = 16'(c2_q) >= last_count(16'(ratio2));
	assign taps  = {dl_q, level_q};
	assign borrow1 = phase1 != '0 && phase1 <= ratio1;

	// -----------------------------------------------------------
	// first stage
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			c1_q <= '0;
		else if (load)
			c1_q <= R1W'(start_count(16'(ratio1), 16'(phase1),
				1'b0)); // see RQ13
		else if (wrap1)
			c1_q <= '0;
		else if (div_tick)
			c1_q <= c1_q + R1W'(1); // see RQ4
	end

	// -----------------------------------------------------------
	// second stage, clocked by first-stage wraps
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			c2_q <= '0;
		else if (load)
			c2_q <= R2W'(start_count(16'(ratio2), 16'(phase2),
				borrow1)); // see RQ13
		else if (wrap1 && wrap2)
			c2_q <= '0;
		else if (wrap1)
			c2_q <= c2_q + R2W'(1); // see RQ5
	end

	// high for the first half of the second-stage count
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			level_q <= 1'b0;
		else
			level_q <= (17'(c2_q) << 1) < 17'(ratio2);
	end

	// -----------------------------------------------------------
	// fine delay line, steps of half an oscillator period
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			dl_q <= '0;
		else if (fine_tick)
			dl_q <= {dl_q[2**FW-3:0], level_q}; // see RQ9
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			clk_out <= 1'b0;
		else if (analog_src)
			clk_out <= taps[fine]; // see RQ8
		else
			clk_out <= level_q; // see RQ11
	end

endmodule

// file: core/output_phase_adjust.sv
// output phase adjuster: axi4-lite registers and twelve output dividers
// Notes on behaviour
// RQ1: each of seven channels has own setting
// RQ2: coarse steps reach 1.6ns
// RQ3: fine steps reach 187.27 ps; the plans here give no step below 193.939 ps (LAN PHY)
// RQ4: stage one unit equals one input period
// RQ5: stage two unit equals one input period; stage two here counts stage one wraps, so its unit is ratio1 input periods
// RQ6: software keeps stage one phase within ratio
// RQ7: software keeps stage two phase within ratio
// RQ8: fine setting acts only on analog source
// RQ9: fine unit is half oscillator period
// RQ10: oscillator rate follows selected clock plan
// RQ11: digital-sourced channel one ignores fine setting
// RQ12: channels eight to twelve have no adjustment
// RQ13: phase offsets start count, frequency unchanged
module output_phase_adjust
	import phase_adjust_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	input  wire logic [NUM_CHANNELS-1:0] div_tick,
	input  wire logic                    fine_tick,
	output logic      [NUM_CHANNELS-1:0] clk_out,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready
);
	import phase_adjust_pkg::*;

	// read-only and unmapped words answer with an error response
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// -----------------------------------------------------------
	// address decode
	// -----------------------------------------------------------
	typedef struct packed
	{
		logic       hit;
		logic       is_ph;
		logic [2:0] chan;
	} chan_decode_type;

	// unaligned or out-of-range addresses miss and answer with an error
	function automatic chan_decode_type decode_chan(input logic [7:0] addr);
		chan_decode_type d;
		logic [7:0] rel;
		d = '0;
		rel = 8'(addr - CHAN_BASE);
		if (addr >= CHAN_BASE && rel < 8'(NUM_ADJ_CHANNELS * CHAN_STRIDE)
			&& addr[1:0] == 2'b00)
		begin
			d.hit   = 1'b1;
			d.chan  = rel[5:3];
			d.is_ph = rel[2:0] == PH_SUB_OFFSET[2:0];
		end
		return d;
	endfunction

	// byte strobes keep the untouched lanes of the stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = data[8*b +: 8];
		return r;
	endfunction

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	// settings survive an align; only the counters restart
	divider_ratio_type ratio_q [NUM_ADJ_CHANNELS];
	phase_setting_type phase_q [NUM_ADJ_CHANNELS];
	vco_plan_type      vco_q;
	logic [NUM_ADJ_CHANNELS-1:0] load_q;
	logic [NUM_ADJ_CHANNELS-1:0] load_d;
	logic              align_q;

	// -----------------------------------------------------------
	// write channel
	// -----------------------------------------------------------
	logic        aw_full_q;
	logic        w_full_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write;
	chan_decode_type wdec;

	// address and data may come in either order; each waits in its
	// holding flop and nothing new is taken while the answer stands
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
	assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wdec          = decode_chan(awaddr_q);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_full_q <= 1'b0;
			awaddr_q  <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		else if (do_write)
			aw_full_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			w_full_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
		else if (do_write)
			w_full_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wdec.hit || awaddr_q == CTRL_OFFSET)
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// per-channel storage; only the written channel changes
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_ADJ_CHANNELS; i++)
			begin
				ratio_q[i] <= '{ratio2: RATIO2_RESET, ratio1: RATIO1_RESET};
				phase_q[i] <= '0;
			end
		end
		else if (do_write && wdec.hit)
		begin
			if (wdec.is_ph)
				phase_q[wdec.chan] <= merge(phase_q[wdec.chan],
					wdata_q, wstrb_q); // see RQ1
			else
				ratio_q[wdec.chan] <= divider_ratio_type'(24'(merge(
					32'(ratio_q[wdec.chan]), wdata_q, wstrb_q)));
		end
	end

	// -----------------------------------------------------------
	// control word
	// -----------------------------------------------------------
	// only the low byte carries fields, so its strobe gates the write
	logic ctrl_wr;

	assign ctrl_wr = do_write && awaddr_q == CTRL_OFFSET && wstrb_q[0];

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			vco_q <= VCO_ETHERNET;
		else if (ctrl_wr)
			vco_q <= vco_plan_type'(wdata_q[CTRL_VCO_LSB +: 2]); // see RQ10
	end

	// align is a one-cycle pulse; the bit reads back as zero
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			align_q <= 1'b0;
		else
			align_q <= ctrl_wr && wdata_q[CTRL_ALIGN_BIT];
	end

	// reload one cycle after the write so the new values are in place;
	// an align write restarts every channel together
	always_comb
	begin
		load_d = '0;
		if (do_write && wdec.hit)
			load_d[wdec.chan] = 1'b1; // see RQ1
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			load_q <= '0;
		else
			load_q <= load_d;
	end

	// -----------------------------------------------------------
	// read channel
	// -----------------------------------------------------------
	logic [31:0] step_fs;
	chan_decode_type rdec;

	// arready drops while an answer stands, so one read is in flight
	assign rdec          = decode_chan(s_axi_araddr);
	assign s_axi_arready = !s_axi_rvalid;

	// the division folds to one constant per plan; no divider is built
	// fine step for the selected plan, shown for software
	always_comb
	begin
		unique case (vco_q)
			VCO_LAN_PHY:
				step_fs = 32'(FS_PER_KHZ_HALF / VCO_LAN_PHY_KHZ); // see RQ10
			VCO_SONET:
				step_fs = 32'(FS_PER_KHZ_HALF / VCO_SONET_KHZ); // see RQ3
			default:
				step_fs = 32'(FS_PER_KHZ_HALF / VCO_ETHERNET_KHZ); // see RQ9
		endcase
	end

	// answer stands until the master takes it
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			s_axi_rvalid <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rresp  <= RESP_OKAY;
			if (rdec.hit)
				s_axi_rdata <= rdec.is_ph ? 32'(phase_q[rdec.chan])
					: 32'(ratio_q[rdec.chan]);
			else if (s_axi_araddr == CTRL_OFFSET)
				s_axi_rdata <= 32'({vco_q, 4'h0});
			else if (s_axi_araddr == STATUS_OFFSET)
				s_axi_rdata <= 32'(clk_out);
			else if (s_axi_araddr == STEP_OFFSET)
				s_axi_rdata <= step_fs;
			else
			begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end
	end

	// -----------------------------------------------------------
	// output channels; coarse step is one divider input period,
	// down to the fastest input the dividers are fed with
	// -----------------------------------------------------------
	// the fixed channels share the align reload so all outputs restart
	// together; no setting reaches their counters
	for (genvar g = 0; g < NUM_CHANNELS; g++)
	begin : gen_chan
		if (g < NUM_ADJ_CHANNELS)
		begin : gen_adj
			phase_divider #(
				.R1W (RATIO1_WIDTH),
				.R2W (RATIO2_WIDTH),
				.FW  (FINE_WIDTH)
			) u_div (
				.sys_clk    (sys_clk),
				.resetn     (resetn),
				.div_tick   (div_tick[g]),
				.fine_tick  (fine_tick),
				.load       (load_q[g] || align_q), // see RQ2
				.ratio1     (ratio_q[g].ratio1),
				.ratio2     (ratio_q[g].ratio2),
				.phase1     (phase_q[g].phase1),
				.phase2     (phase_q[g].phase2),
				.fine       (phase_q[g].fine),
				.analog_src (phase_q[g].analog_src), // see RQ8
				.clk_out    (clk_out[g])
			);
		end
		else
		begin : gen_plain
			// fixed divide by two, no setting reaches these
			phase_divider #(
				.R1W (RATIO1_WIDTH),
				.R2W (RATIO2_WIDTH),
				.FW  (FINE_WIDTH)
			) u_div (
				.sys_clk    (sys_clk),
				.resetn     (resetn),
				.div_tick   (div_tick[g]),
				.fine_tick  (1'b0),
				.load       (align_q),
				.ratio1     (RATIO1_RESET),
				.ratio2     (RATIO2_RESET),
				.phase1     ('0), // see RQ12
				.phase2     ('0), // see RQ12
				.fine       ('0),
				.analog_src (1'b0),
				.clk_out    (clk_out[g])
			);
		end
	end

endmodule

// file: dv/phase_adjust_monitor.sv
// port checker for the output phase adjuster
module phase_adjust_monitor
(
	input wire logic                                  sys_clk,
	input wire logic                                  resetn,
	input wire logic [phase_adjust_pkg::NUM_CHANNELS-1:0] div_tick,
	input wire logic [phase_adjust_pkg::NUM_CHANNELS-1:0] clk_out,
	input wire logic                                  s_axi_awvalid,
	input wire logic                                  s_axi_awready,
	input wire logic                                  s_axi_wvalid,
	input wire logic                                  s_axi_wready,
	input wire logic [1:0]                            s_axi_bresp,
	input wire logic                                  s_axi_bvalid,
	input wire logic                                  s_axi_bready,
	input wire logic [7:0]                            s_axi_araddr,
	input wire logic                                  s_axi_arvalid,
	input wire logic                                  s_axi_arready,
	input wire logic [31:0]                           s_axi_rdata,
	input wire logic [1:0]                            s_axi_rresp,
	input wire logic                                  s_axi_rvalid,
	input wire logic                                  s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	import phase_adjust_pkg::*;

	// -----------------------------------------------------------
	// helper counters
	// -----------------------------------------------------------
	// a register write may realign the fixed channels, so wait it out
	logic [3:0] quiet_q;
	logic [3:0] run_q;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			quiet_q <= 4'h0;
		else if (s_axi_wvalid)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			run_q <= 4'h0;
		else if (!div_tick[7])
			run_q <= 4'h0;
		else if (run_q != 4'hf)
			run_q <= run_q + 4'h1;
	end

	// -----------------------------------------------------------
	// properties
	// -----------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h44;
	endsequence
	sequence fixed_rise;
		quiet_q > 4'h6 && run_q > 4'h6 && $rose(clk_out[7]);
	endsequence

	chk_b_answer: assert property
		(wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_b_hold: assert property
		(s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_b_block: assert property
		(s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_r_answer: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_r_hold: assert property
		(s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_ar_gate: assert property
		(s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	chk_r_unmapped: assert property
		(rd_unmapped |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	chk_fixed_rate: assert property
		(fixed_rise |=> !clk_out[7] ##1 clk_out[7])
		else $error("fixed channel period wrong");
endmodule

bind output_phase_adjust phase_adjust_monitor u_phase_adjust_monitor
(
	.sys_clk(sys_clk), .resetn(resetn), .div_tick(div_tick),
	.clk_out(clk_out), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// file: dv/tb_top.sv
// self-checking bench for the output phase adjuster
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import phase_adjust_pkg::*;

	logic                    sys_clk = 1'b0;
	logic                    resetn = 1'b0;
	logic [NUM_CHANNELS-1:0] div_tick = '1;
	logic                    fine_tick = 1'b1;
	logic [NUM_CHANNELS-1:0] clk_out;
	logic [7:0]              s_axi_awaddr = 8'h00;
	logic [7:0]              s_axi_araddr = 8'h00;
	logic [31:0]             s_axi_wdata = 32'h0000_0000;
	logic [3:0]              s_axi_wstrb = 4'hf;
	logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                    s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic                    s_axi_rready = 1'b0;
	logic                    s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                    s_axi_arready, s_axi_rvalid;
	logic [1:0]              s_axi_bresp, s_axi_rresp;
	logic [31:0]             s_axi_rdata;
	logic [33:0]             rq[$];
	logic [1:0]              bq[$];
	logic [31:0]             seed = 32'h0000_000b;
	int unsigned             khz[3] = '{VCO_ETHERNET_KHZ, VCO_LAN_PHY_KHZ,
	                                    VCO_SONET_KHZ};
	int                      num_errors = 0, checked = 0, cyc = 0;
	int                      d, pg, v;

	output_phase_adjust u_output_phase_adjust
	(
		.sys_clk(sys_clk), .resetn(resetn), .div_tick(div_tick),
		.fine_tick(fine_tick), .clk_out(clk_out),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	always #2 sys_clk = ~sys_clk;

	// -----------------------------------------------------------
	// helpers and compares
	// -----------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] sub);
		return 8'(CHAN_BASE + CHAN_STRIDE * ch + sub);
	endfunction

	task automatic cmp_word(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %0t read %h want %h", $time, got, exp);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %0t bresp %b want %b", $time, got, exp);
		end
	endtask

	task automatic cmp_num(input int got, input int exp);
		checked++;
		if (got != exp)
		begin
			num_errors++;
			$display("unexpected %0t edge gap %0d want %0d", $time, got, exp);
		end
	endtask

	// response ready starts at random so the slave must hold its answer
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] w,
		input logic [1:0] r);
		@(posedge sys_clk);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'(xs());
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (!s_axi_bready)
				s_axi_bready <= 1'b1;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge sys_clk);
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'(xs());
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (!s_axi_rready)
				s_axi_rready <= 1'b1;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
	endtask

	always @(posedge sys_clk)
	begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
			cmp_word({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
			cmp_resp(s_axi_bresp, bq.pop_front());
	end

	// delay of channel a behind channel b, modulo r, and a's own period
	task automatic meas(input int a, input int b, input int r,
		output int dl, output int per);
		int ta, a2, tb, n;
		logic la, lb;
		ta = -1;
		a2 = -1;
		tb = -1;
		n = 0;
		la = 1'b1;
		lb = 1'b1;
		while ((a2 < 0 || tb < 0) && n < 300)
		begin
			@(negedge sys_clk);
			n++;
			if (clk_out[a] && !la && ta >= 0 && a2 < 0)
				a2 = n;
			if (clk_out[a] && !la && ta < 0)
				ta = n;
			if (clk_out[b] && !lb && tb < 0)
				tb = n;
			la = clk_out[a];
			lb = clk_out[b];
		end
		dl = ((ta - tb) % r + r) % r;
		per = a2 - ta;
	endtask

	task automatic run_case(input int ch, r1, r2, p1, p2, f, src, expd);
		int rf;
		logic [31:0] dv;
		logic [31:0] pv;
		rf = (ch + 1) % NUM_ADJ_CHANNELS;
		dv = {8'h00, r2[15:0], r1[7:0]};
		pv = {src[0], 3'b000, f[3:0], p2[15:0], p1[7:0]};
		axi_wr(ch_addr(ch, DIV_SUB_OFFSET), dv, 2'b00);
		axi_wr(ch_addr(rf, DIV_SUB_OFFSET), dv, 2'b00);
		axi_wr(ch_addr(ch, PH_SUB_OFFSET), pv, 2'b00);
		axi_wr(ch_addr(rf, PH_SUB_OFFSET), {src[0], 31'h0}, 2'b00);
		axi_wr(CTRL_OFFSET, 32'h0000_0001, 2'b00);
		axi_rd(ch_addr(ch, PH_SUB_OFFSET), {2'b00, pv});
		// the fine line must refill past the align before edges count
		repeat (20) @(posedge sys_clk);
		meas(ch, rf, r1 * r2, d, pg);
		cmp_num(d, expd);
		cmp_num(pg, r1 * r2);
	endtask

	task automatic close_out();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		axi_rd(ch_addr(0, DIV_SUB_OFFSET), 34'h0_0000_0201);
		axi_rd(ch_addr(3, PH_SUB_OFFSET), 34'h0_0000_0000);
		axi_rd(8'hf0, 34'h2_0000_0000);
		axi_wr(8'hf0, 32'h1234_5678, 2'b10);
		s_axi_wstrb <= 4'h1;
		axi_wr(ch_addr(3, DIV_SUB_OFFSET), 32'hffff_ff05, 2'b00);
		s_axi_wstrb <= 4'hf;
		axi_rd(ch_addr(3, DIV_SUB_OFFSET), 34'h0_0000_0205);
		for (int p = 0; p < 3; p++)
		begin
			axi_wr(CTRL_OFFSET, 32'(p) << CTRL_VCO_LSB, 2'b00);
			axi_rd(STEP_OFFSET, {2'b00, 32'(FS_PER_KHZ_HALF / khz[p])});
		end
		v = 1 + int'(xs() % 32'd19);
		run_case(0, 1, 20, 0, v, 0, 0, v);
		v = 1 + int'(xs() % 32'd3);
		run_case(2, 3, 4, v, 0, 0, 0, v);
		v = 1 + int'(xs() % 32'd15);
		run_case(4, 1, 20, 0, 0, v, 1, v);
		run_case(0, 1, 20, 0, 0, 7, 0, 0);
		run_case(6, 2, 6, 1, 2, 0, 0, 5);
		meas(7, 8, 2, d, pg);
		cmp_num(d, 0);
		cmp_num(pg, 2);
		close_out();
	end
endmodule
